//--- src/tci_defines.vh
`ifndef TCI_DEFINES_VH
`define TCI_DEFINES_VH
// Framing and reply characters
`define TCI_STX 8'h02
`define TCI_CR 8'h0d
`define TCI_COMMA 8'h2c
`define TCI_ACK 8'h41
`define TCI_NAK 8'h45
// Command characters
`define TCI_CMD_SEL 8'h44
`define TCI_CMD_SETNUM 8'h49
`define TCI_CMD_GETNUM 8'h59
`define TCI_CMD_SETTIME 8'h53
`define TCI_CMD_GETTIME 8'h54
`define TCI_CMD_VER 8'h56
`define TCI_CMD_INIT 8'h52
`define TCI_CMD_SET1 8'h43
`define TCI_CMD_GET1 8'h42
`define TCI_CMD_SET2 8'h50
`define TCI_CMD_GET2 8'h51
`define TCI_CMD_SET3 8'h4a
`define TCI_CMD_GET3 8'h4b
// Error codes
`define TCI_ERR_INVALID 8'h04
`define TCI_ERR_FAIL 8'h07
`define TCI_ERR_BUSY 8'h09
// Unit numbers
`define TCI_UNIT_UNIVERSAL 16'h0000
`define TCI_UNIT_MAX 16'h270f
`define TCI_UNIT_RST 16'h0001
// Banks and entries
`define TCI_BANK1 2'h0
`define TCI_BANK2 2'h1
`define TCI_BANK3 2'h2
`define TCI_WEEK_ENTRIES 8'he0
`define TCI_FACTORY_VAL 8'h00
`define TCI_MEM_AW 10
`define TCI_MEM_DW 8
`define TCI_MEM_DEPTH 768
`define TCI_MEM_LAST 10'h2ff
// Packet lengths, command character included
`define TCI_LEN_NONE 5'd1
`define TCI_LEN_UNIT 5'd5
`define TCI_LEN_TIME 5'd15
`define TCI_LEN_IDX 5'd3
`define TCI_LEN_SETMIN 5'd5
`define TCI_LEN_SETMAX 5'd6
// Reply body lengths
`define TCI_RLEN_ACK 7'd1
`define TCI_RLEN_UNIT 7'd5
`define TCI_RLEN_TIME 7'd15
`define TCI_RLEN_VER 7'd15
`define TCI_RLEN_CODE 7'd3
// Clock and display
`define TCI_TIME_DEFAULT 56'h19990101000000
`define TCI_DISP_INIT 32'h494e4954
`define TCI_DISP_BLANK 32'h20202020
`endif

//--- src/tci_bank_mem.v
`timescale 1ns/1ps
`include "tci_defines.vh"
module tci_bank_mem #(
  parameter AW = `TCI_MEM_AW,
  parameter DW = `TCI_MEM_DW,
  parameter DEPTH = `TCI_MEM_DEPTH
) (
  input wire clk,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:DEPTH-1];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

//--- src/tci_cal_check.v
`timescale 1ns/1ps
module tci_cal_check (
  input wire [55:0] bcd,
  output reg ok
);
  reg digits_ok;
  reg leap;
  reg [13:0] yr;
  reg [7:0] mon;
  reg [7:0] day;
  reg [7:0] dim;
  integer i;

  always @* begin
    digits_ok = 1'b1;
    for (i = 0; i < 14; i = i + 1) begin
      if (bcd[4*i +: 4] > 4'h9) begin
        digits_ok = 1'b0;
      end
    end
    yr = bcd[55:52] * 14'd1000 + bcd[51:48] * 14'd100 + bcd[47:44] * 14'd10 + bcd[43:40];
    leap = (yr[1:0] == 2'h0) && (((yr % 14'd100) != 14'd0) || ((yr % 14'd400) == 14'd0));
    mon = bcd[39:32];
    day = bcd[31:24];
    case (mon)
      8'h02: dim = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: dim = 8'h30;
      default: dim = 8'h31;
    endcase
    ok = digits_ok && (mon >= 8'h01) && (mon <= 8'h12) && (day >= 8'h01) && (day <= dim) &&
      (bcd[23:16] <= 8'h23) && (bcd[15:8] <= 8'h59) && (bcd[7:0] <= 8'h59);
  end
endmodule

//--- src/tci_top.v
`timescale 1ns/1ps
`include "tci_defines.vh"
// Contract
// - Start deselected; ignore commands until select names own or universal number.
// - Once selected answer everything; another number in a select deselects; code instead keeps the selection while STORE_FAULT is high.
// - Select reply carries own number; 0000 only when it cannot be read.
// - Select never answers with an error; malformed or unreadable stays silent.
// - Unit number is four hex digits up to 270F; 0000 selects anyone.
// - Set number stores it and acknowledges; 04 bad data, 07 failure.
// - Get number returns acknowledge and four hex digits; 07 on failure.
// - Set time takes fourteen digits; loads only valid calendar time, else 04.
// - Get time returns acknowledge and fourteen digits; 07 on failure.
// - Version reply is acknowledge plus printable text up to 61 characters.
// - Version text is V, dotted number, one space, then a comment.
// - Initialize is only acknowledged and scheduled; runs at next power-up.
// - Deferred init fixes invalid clock to 1999/01/01 00:00:00, keeps records; code instead clears all 768 bank entries to 00.
// - Initialize refused with 09 while real-time sending is busy.
// - Display shows INIT while power-up initialization runs.
// - Bank one write takes index, comma, value; acknowledge or 04/07.
// - Bank one read returns acknowledge, value, checksum; 04/07 on failure.
// - Bank two write covers 7x32 bell times; 04/07 on failure.
// - Bank two read returns acknowledge, value, checksum; 04/07 on failure.
// - Bank three write covers 7x32 bell enables; acknowledge or 04/07.
// - Packets framed by STX and CR; checksum is low byte sum in hex.
// - Errors: 04 invalid, 07 internal failure, 09 not possible now.
module tci_top #(
  parameter AW = `TCI_MEM_AW,
  parameter DW = `TCI_MEM_DW,
  parameter DEPTH = `TCI_MEM_DEPTH
) (
  input wire MCLK,
  input wire SYS_RST,
  input wire [7:0] RX_DATA,
  input wire RX_VALID,
  output reg [7:0] TX_DATA,
  output reg TX_VALID,
  input wire TX_READY,
  input wire [55:0] RTC_TIME,
  output reg RTC_LOAD,
  output reg [55:0] RTC_LOAD_VALUE,
  input wire STORE_FAULT,
  input wire RT_BUSY,
  input wire INIT_SCHEDULED,
  output reg INIT_REQ,
  output reg INIT_CLEAR,
  output reg [31:0] DISP_TEXT,
  output reg SELECTED,
  output reg [15:0] UNIT_NUMBER
);
  localparam ST_BOOT = 3'd0;
  localparam ST_INIT = 3'd1;
  localparam ST_IDLE = 3'd2;
  localparam ST_RECV = 3'd3;
  localparam ST_EXEC = 3'd4;
  localparam ST_MEMRD = 3'd5;
  localparam ST_SEND = 3'd6;

  localparam RK_ACK = 3'd0;
  localparam RK_UNIT = 3'd1;
  localparam RK_TIME = 3'd2;
  localparam RK_VER = 3'd3;
  localparam RK_DATA = 3'd4;
  localparam RK_ERR = 3'd5;

  reg [2:0] state_r;
  reg [7:0] cmd_r;
  reg [4:0] cnt_r;
  reg bad_r;
  reg [15:0] acc_r;
  reg [55:0] bcd_r;
  reg [7:0] idx_r;
  reg [2:0] kind_r;
  reg [55:0] pay_r;
  reg [6:0] tx_pos_r;
  reg [7:0] sum_r;
  reg [AW-1:0] clr_addr_r;
  reg mem_we_r;
  reg [AW-1:0] mem_waddr_r;
  reg [DW-1:0] mem_wdata_r;
  wire [DW-1:0] mem_rdata;
  wire cal_ok;
  wire [55:0] cal_in;
  reg len_ok;
  reg [6:0] body_len;
  reg [6:0] total;
  reg [7:0] out_byte;
  reg [6:0] b;
  wire good;
  wire setbank;
  wire getbank;
  wire [1:0] bank;
  wire [7:0] eff_idx;
  wire idx_bad;

  function is_hex;
    input [7:0] c;
    begin
      is_hex = ((c >= 8'h30) && (c <= 8'h39)) || ((c >= 8'h41) && (c <= 8'h46)) ||
        ((c >= 8'h61) && (c <= 8'h66));
    end
  endfunction

  function [3:0] hex_val;
    input [7:0] c;
    begin
      if (c <= 8'h39) begin
        hex_val = c[3:0];
      end else begin
        hex_val = c[3:0] + 4'h9;
      end
    end
  endfunction

  function [7:0] hex_chr;
    input [3:0] n;
    begin
      if (n <= 4'h9) begin
        hex_chr = {4'h3, n};
      end else begin
        hex_chr = {4'h0, n} + 8'h37;
      end
    end
  endfunction

  function [1:0] bank_of;
    input [7:0] c;
    begin
      case (c)
        `TCI_CMD_SET1, `TCI_CMD_GET1: bank_of = `TCI_BANK1;
        `TCI_CMD_SET2, `TCI_CMD_GET2: bank_of = `TCI_BANK2;
        default: bank_of = `TCI_BANK3;
      endcase
    end
  endfunction

  function [7:0] ver_byte;
    input [6:0] i;
    begin
      case (i)
        7'd0: ver_byte = 8'h56;
        7'd1: ver_byte = 8'h31;
        7'd2: ver_byte = 8'h2e;
        7'd3: ver_byte = 8'h30;
        7'd4: ver_byte = 8'h30;
        7'd5: ver_byte = 8'h20;
        7'd6: ver_byte = 8'h43;
        7'd7: ver_byte = 8'h4d;
        7'd8: ver_byte = 8'h44;
        7'd9: ver_byte = 8'h20;
        7'd10: ver_byte = 8'h43;
        7'd11: ver_byte = 8'h4f;
        7'd12: ver_byte = 8'h52;
        default: ver_byte = 8'h45;
      endcase
    end
  endfunction

  assign setbank = (cmd_r == `TCI_CMD_SET1) || (cmd_r == `TCI_CMD_SET2) ||
    (cmd_r == `TCI_CMD_SET3);
  assign getbank = (cmd_r == `TCI_CMD_GET1) || (cmd_r == `TCI_CMD_GET2) ||
    (cmd_r == `TCI_CMD_GET3);
  assign bank = bank_of(cmd_r);
  assign eff_idx = setbank ? idx_r : acc_r[7:0];
  assign idx_bad = (bank != `TCI_BANK1) && (eff_idx >= `TCI_WEEK_ENTRIES);
  assign good = len_ok && !bad_r;
  assign cal_in = (cmd_r == `TCI_CMD_SETTIME && state_r == ST_EXEC) ? bcd_r : RTC_TIME;

  tci_cal_check u_cal (
    .bcd(cal_in),
    .ok(cal_ok)
  );

  tci_bank_mem #(
    .AW(AW),
    .DW(DW),
    .DEPTH(DEPTH)
  ) u_mem (
    .clk(MCLK),
    .we(mem_we_r),
    .waddr(mem_waddr_r),
    .wdata(mem_wdata_r),
    .raddr({bank, acc_r[7:0]}),
    .rdata(mem_rdata)
  );

  always @* begin
    case (cmd_r)
      `TCI_CMD_SEL, `TCI_CMD_SETNUM: len_ok = (cnt_r == `TCI_LEN_UNIT);
      `TCI_CMD_SETTIME: len_ok = (cnt_r == `TCI_LEN_TIME);
      `TCI_CMD_GET1, `TCI_CMD_GET2, `TCI_CMD_GET3: len_ok = (cnt_r == `TCI_LEN_IDX);
      `TCI_CMD_SET1, `TCI_CMD_SET2, `TCI_CMD_SET3:
        len_ok = (cnt_r == `TCI_LEN_SETMIN) || (cnt_r == `TCI_LEN_SETMAX);
      default: len_ok = (cnt_r == `TCI_LEN_NONE);
    endcase
  end

  always @* begin
    case (kind_r)
      RK_ACK: body_len = `TCI_RLEN_ACK;
      RK_UNIT: body_len = `TCI_RLEN_UNIT;
      RK_TIME: body_len = `TCI_RLEN_TIME;
      RK_VER: body_len = `TCI_RLEN_VER;
      default: body_len = `TCI_RLEN_CODE;
    endcase
    total = body_len + ((kind_r == RK_DATA) ? 7'd4 : 7'd2);
    b = tx_pos_r - 7'd1;
    if (tx_pos_r == 7'd0) begin
      out_byte = `TCI_STX;
    end else if (tx_pos_r == total - 7'd1) begin
      out_byte = `TCI_CR;
    end else if (tx_pos_r == body_len + 7'd1) begin
      out_byte = hex_chr(sum_r[7:4]);
    end else if (tx_pos_r == body_len + 7'd2) begin
      out_byte = hex_chr(sum_r[3:0]);
    end else if (b == 7'd0) begin
      out_byte = (kind_r == RK_ERR) ? `TCI_NAK : `TCI_ACK;
    end else if (kind_r == RK_VER) begin
      out_byte = ver_byte(b - 7'd1);
    end else begin
      out_byte = hex_chr(pay_r[(59 - 4 * b) -: 4]);
    end
  end

  always @(posedge MCLK) begin
    if (SYS_RST) begin
      state_r <= ST_BOOT;
      cmd_r <= 8'h00;
      cnt_r <= 5'h00;
      bad_r <= 1'b0;
      acc_r <= 16'h0000;
      bcd_r <= 56'h0;
      idx_r <= 8'h00;
      kind_r <= RK_ACK;
      pay_r <= 56'h0;
      tx_pos_r <= 7'h00;
      sum_r <= 8'h00;
      clr_addr_r <= {AW{1'b0}};
      mem_we_r <= 1'b0;
      mem_waddr_r <= {AW{1'b0}};
      mem_wdata_r <= {DW{1'b0}};
      TX_DATA <= 8'h00;
      TX_VALID <= 1'b0;
      RTC_LOAD <= 1'b0;
      RTC_LOAD_VALUE <= 56'h0;
      INIT_REQ <= 1'b0;
      INIT_CLEAR <= 1'b0;
      DISP_TEXT <= `TCI_DISP_BLANK;
      SELECTED <= 1'b0;
      UNIT_NUMBER <= `TCI_UNIT_RST;
    end else begin
      mem_we_r <= 1'b0;
      RTC_LOAD <= 1'b0;
      INIT_CLEAR <= 1'b0;
      case (state_r)
        ST_BOOT: begin
          if (INIT_SCHEDULED) begin
            DISP_TEXT <= `TCI_DISP_INIT;
            clr_addr_r <= {AW{1'b0}};
            state_r <= ST_INIT;
          end else begin
            state_r <= ST_IDLE;
          end
        end
        ST_INIT: begin
          mem_we_r <= 1'b1;
          mem_waddr_r <= clr_addr_r;
          mem_wdata_r <= `TCI_FACTORY_VAL;
          clr_addr_r <= clr_addr_r + {{(AW-1){1'b0}}, 1'b1};
          if (clr_addr_r == DEPTH - 1) begin
            if (!cal_ok) begin
              RTC_LOAD <= 1'b1;
              RTC_LOAD_VALUE <= `TCI_TIME_DEFAULT;
            end
            INIT_CLEAR <= 1'b1;
            DISP_TEXT <= `TCI_DISP_BLANK;
            state_r <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (RX_VALID && RX_DATA == `TCI_STX) begin
            cnt_r <= 5'h00;
            bad_r <= 1'b0;
            acc_r <= 16'h0000;
            state_r <= ST_RECV;
          end
        end
        ST_RECV: begin
          if (RX_VALID) begin
            if (RX_DATA == `TCI_CR) begin
              state_r <= ST_EXEC;
            end else if (RX_DATA == `TCI_STX) begin
              cnt_r <= 5'h00;
              bad_r <= 1'b0;
              acc_r <= 16'h0000;
            end else begin
              if (cnt_r != 5'h1f) begin
                cnt_r <= cnt_r + 5'h01;
              end
              if (cnt_r == 5'h00) begin
                cmd_r <= RX_DATA;
              end else if (setbank && cnt_r == 5'h03) begin
                if (RX_DATA != `TCI_COMMA) begin
                  bad_r <= 1'b1;
                end
                idx_r <= acc_r[7:0];
                acc_r <= 16'h0000;
              end else if (cmd_r == `TCI_CMD_SETTIME) begin
                if (RX_DATA < 8'h30 || RX_DATA > 8'h39) begin
                  bad_r <= 1'b1;
                end
                bcd_r <= {bcd_r[51:0], RX_DATA[3:0]};
              end else begin
                if (!is_hex(RX_DATA)) begin
                  bad_r <= 1'b1;
                end
                acc_r <= {acc_r[11:0], hex_val(RX_DATA)};
              end
            end
          end
        end
        ST_EXEC: begin
          tx_pos_r <= 7'h00;
          sum_r <= 8'h00;
          state_r <= ST_SEND;
          kind_r <= RK_ACK;
          if (cmd_r == `TCI_CMD_SEL) begin
            if (!good || acc_r > `TCI_UNIT_MAX) begin
              state_r <= ST_IDLE;
            end else if (acc_r == `TCI_UNIT_UNIVERSAL) begin
              SELECTED <= 1'b1;
              kind_r <= RK_UNIT;
              pay_r <= {(STORE_FAULT ? `TCI_UNIT_UNIVERSAL : UNIT_NUMBER), 40'h0};
            end else if (STORE_FAULT) begin
              state_r <= ST_IDLE;
            end else if (acc_r == UNIT_NUMBER) begin
              SELECTED <= 1'b1;
              kind_r <= RK_UNIT;
              pay_r <= {UNIT_NUMBER, 40'h0};
            end else begin
              SELECTED <= 1'b0;
              state_r <= ST_IDLE;
            end
          end else if (!SELECTED) begin
            state_r <= ST_IDLE;
          end else begin
            kind_r <= RK_ERR;
            pay_r <= {`TCI_ERR_INVALID, 48'h0};
            case (cmd_r)
              `TCI_CMD_SETNUM: begin
                if (good && acc_r <= `TCI_UNIT_MAX) begin
                  if (STORE_FAULT) begin
                    pay_r <= {`TCI_ERR_FAIL, 48'h0};
                  end else begin
                    UNIT_NUMBER <= acc_r;
                    kind_r <= RK_ACK;
                  end
                end
              end
              `TCI_CMD_GETNUM: begin
                if (STORE_FAULT) begin
                  pay_r <= {`TCI_ERR_FAIL, 48'h0};
                end else begin
                  kind_r <= RK_UNIT;
                  pay_r <= {UNIT_NUMBER, 40'h0};
                end
              end
              `TCI_CMD_SETTIME: begin
                if (good && cal_ok) begin
                  if (STORE_FAULT) begin
                    pay_r <= {`TCI_ERR_FAIL, 48'h0};
                  end else begin
                    RTC_LOAD <= 1'b1;
                    RTC_LOAD_VALUE <= bcd_r;
                    kind_r <= RK_ACK;
                  end
                end
              end
              `TCI_CMD_GETTIME: begin
                if (!cal_ok) begin
                  pay_r <= {`TCI_ERR_FAIL, 48'h0};
                end else begin
                  kind_r <= RK_TIME;
                  pay_r <= RTC_TIME;
                end
              end
              `TCI_CMD_VER: begin
                kind_r <= RK_VER;
              end
              `TCI_CMD_INIT: begin
                if (RT_BUSY) begin
                  pay_r <= {`TCI_ERR_BUSY, 48'h0};
                end else begin
                  INIT_REQ <= 1'b1;
                  kind_r <= RK_ACK;
                end
              end
              `TCI_CMD_SET1, `TCI_CMD_SET2, `TCI_CMD_SET3: begin
                if (good && !idx_bad) begin
                  if (STORE_FAULT) begin
                    pay_r <= {`TCI_ERR_FAIL, 48'h0};
                  end else begin
                    mem_we_r <= 1'b1;
                    mem_waddr_r <= {bank, idx_r};
                    mem_wdata_r <= acc_r[7:0];
                    kind_r <= RK_ACK;
                  end
                end
              end
              `TCI_CMD_GET1, `TCI_CMD_GET2, `TCI_CMD_GET3: begin
                if (good && !idx_bad) begin
                  if (STORE_FAULT) begin
                    pay_r <= {`TCI_ERR_FAIL, 48'h0};
                  end else begin
                    state_r <= ST_MEMRD;
                  end
                end
              end
              default: begin
                pay_r <= {`TCI_ERR_INVALID, 48'h0};
              end
            endcase
          end
        end
        ST_MEMRD: begin
          kind_r <= RK_DATA;
          pay_r <= {mem_rdata, 48'h0};
          state_r <= ST_SEND;
        end
        ST_SEND: begin
          if (!TX_VALID || TX_READY) begin
            if (tx_pos_r == total) begin
              TX_VALID <= 1'b0;
              state_r <= ST_IDLE;
            end else begin
              TX_DATA <= out_byte;
              TX_VALID <= 1'b1;
              tx_pos_r <= tx_pos_r + 7'd1;
              if (tx_pos_r != 7'd0 && tx_pos_r <= body_len) begin
                sum_r <= sum_r + out_byte;
              end
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

//--- testbench/tci_top_properties.sv
`timescale 1ns/1ps
module tci_top_chk (
  input wire MCLK,
  input wire SYS_RST,
  input wire [7:0] RX_DATA,
  input wire RX_VALID,
  input wire [7:0] TX_DATA,
  input wire TX_VALID,
  input wire TX_READY,
  input wire RT_BUSY,
  input wire RTC_LOAD,
  input wire [55:0] RTC_LOAD_VALUE,
  input wire INIT_REQ,
  input wire INIT_CLEAR,
  input wire [31:0] DISP_TEXT,
  input wire SELECTED,
  input wire [15:0] UNIT_NUMBER
);
  reg [3:0] cr_age_r;
  reg tx_pkt_r;
  // Cycles since a packet end and reply framing state
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      cr_age_r <= 4'hf;
      tx_pkt_r <= 1'b0;
    end else begin
      if (RX_VALID && RX_DATA == 8'h0d) cr_age_r <= 4'h0;
      else if (cr_age_r != 4'hf) cr_age_r <= cr_age_r + 4'h1;
      if (TX_VALID && TX_READY) tx_pkt_r <= (TX_DATA != 8'h0d);
    end
  end
  default clocking dcb @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);
  property p_sel_rise;
    $rose(SELECTED) |-> cr_age_r <= 4'h3;
  endproperty
  a_sel_rise: assert property (p_sel_rise) else $error("select without command");
  property p_sel_fall;
    $fell(SELECTED) |-> cr_age_r <= 4'h3;
  endproperty
  a_sel_fall: assert property (p_sel_fall) else $error("deselect without command");
  property p_tx_start;
    TX_VALID && !tx_pkt_r |-> TX_DATA == 8'h02;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("reply not opened by start");
  property p_tx_hold;
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("reply byte dropped");
  property p_printable;
    TX_VALID && tx_pkt_r && TX_DATA != 8'h0d |-> TX_DATA >= 8'h20 && TX_DATA <= 8'h7f;
  endproperty
  a_printable: assert property (p_printable) else $error("reply char out of range");
  property p_unit;
    UNIT_NUMBER <= 16'h270f;
  endproperty
  a_unit: assert property (p_unit) else $error("unit number out of range");
  property p_init;
    $rose(INIT_REQ) |-> cr_age_r <= 4'h3 && !RT_BUSY;
  endproperty
  a_init: assert property (p_init) else $error("init scheduled wrongly");
  property p_disp;
    INIT_CLEAR |-> ##[0:1] DISP_TEXT == 32'h20202020;
  endproperty
  a_disp: assert property (p_disp) else $error("display not cleared");
  property p_rtc_pulse;
    RTC_LOAD |=> !RTC_LOAD;
  endproperty
  a_rtc_pulse: assert property (p_rtc_pulse) else $error("clock load too long");
  property p_rtc_dflt;
    RTC_LOAD && cr_age_r > 4'h8 |-> RTC_LOAD_VALUE == 56'h19990101000000;
  endproperty
  a_rtc_dflt: assert property (p_rtc_dflt) else $error("wrong default time");
endmodule
bind tci_top tci_top_chk tci_top_chk_inst (.MCLK(MCLK), .SYS_RST(SYS_RST),
  .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
  .TX_READY(TX_READY), .RT_BUSY(RT_BUSY), .RTC_LOAD(RTC_LOAD),
  .RTC_LOAD_VALUE(RTC_LOAD_VALUE), .INIT_REQ(INIT_REQ), .INIT_CLEAR(INIT_CLEAR),
  .DISP_TEXT(DISP_TEXT), .SELECTED(SELECTED), .UNIT_NUMBER(UNIT_NUMBER));

//--- testbench/tci_host_model.sv
`timescale 1ns/1ps
module tci_host_model (
  input wire clk,
  input wire slow,
  output reg [7:0] rx_data,
  output reg rx_valid,
  input wire [7:0] tx_data,
  input wire tx_valid,
  output reg tx_ready
);
  string reply;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // Stalls the reply side when asked
  always @(posedge clk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  task put(input logic [7:0] c);
    @(posedge clk);
    rx_data <= c;
    rx_valid <= 1'b1;
  endtask
  task send(input string s);
    int n;
    reply = "";
    put(8'h02);
    for (int i = 0; i < s.len(); i++) put(s[i]);
    put(8'h0d);
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    n = 0;
    while (n < 40) begin
      @(posedge clk);
      if (tx_valid && tx_ready) begin
        n = 0;
        if (tx_data == 8'h0d) break;
        if (tx_data != 8'h02) reply = {reply, string'(tx_data)};
      end else n++;
    end
    @(posedge clk);
  endtask
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg mclk = 1'b0;
  reg sys_rst = 1'b1;
  reg [55:0] rtc_time = 56'h20240131235959;
  reg store_fault = 1'b0;
  reg rt_busy = 1'b0;
  reg init_scheduled = 1'b0;
  reg slow = 1'b0;
  wire [7:0] rx_data, tx_data;
  wire rx_valid, tx_valid, tx_ready, rtc_load, init_req, init_clear, selected;
  wire [55:0] rtc_load_value;
  wire [31:0] disp_text;
  wire [15:0] unit_number;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  string cmd[] = '{"Y", "D0002", "D0000", "Y", "I0123", "Y", "I2710", "I12G4", "D01", "V",
    "S20000229123456", "S19000229000000", "T", "C05,7F", "B05", "PDF,3", "QDF", "PE0,1",
    "JDF,A", "KDF", "JE0,1", "Z", "D0005", "Y", "D0123"};
  string exp[] = '{"", "", "A0001", "A0001", "A", "A0123", "E04", "E04", "",
    "AV1.00 CMD CORE", "A", "E04", "A20240131235959", "A", "A7FBE", "A", "A03A4", "E04",
    "A", "A0AB2", "E04", "E04", "", "", "A0123"};
  tci_top tci_top_inst (.MCLK(mclk), .SYS_RST(sys_rst), .RX_DATA(rx_data),
    .RX_VALID(rx_valid), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
    .RTC_TIME(rtc_time), .RTC_LOAD(rtc_load), .RTC_LOAD_VALUE(rtc_load_value),
    .STORE_FAULT(store_fault), .RT_BUSY(rt_busy), .INIT_SCHEDULED(init_scheduled),
    .INIT_REQ(init_req), .INIT_CLEAR(init_clear), .DISP_TEXT(disp_text),
    .SELECTED(selected), .UNIT_NUMBER(unit_number));
  tci_host_model tci_host_model_inst (.clk(mclk), .slow(slow), .rx_data(rx_data),
    .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  always #4 mclk = ~mclk;
  task finish_test();
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end
  task check_val(input logic [55:0] got, input logic [55:0] want);
    samples_checked++;
    if (got !== want) begin
      err_count++;
      $display("unexpected value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task exchange(input string c, input string want);
    tci_host_model_inst.send(c);
    samples_checked++;
    if (tci_host_model_inst.reply != want) begin
      err_count++;
      $display("unexpected reply at %0t to %s: got '%s' want '%s'", $time, c,
        tci_host_model_inst.reply, want);
    end
  endtask
  initial begin
    int n;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < cmd.size(); i++) begin
      slow <= i[0];
      exchange(cmd[i], exp[i]);
    end
    slow <= 1'b0;
    check_val(rtc_load_value, 56'h20000229123456);
    rt_busy <= 1'b1;
    exchange("R", "E09");
    check_val(init_req, 1'b0);
    rt_busy <= 1'b0;
    exchange("R", "A");
    check_val(init_req, 1'b1);
    store_fault <= 1'b1;
    exchange("Y", "E07");
    exchange("I0001", "E07");
    exchange("S20240101000000", "E07");
    exchange("C05,1", "E07");
    exchange("B05", "E07");
    exchange("D0123", "");
    exchange("D0000", "A0000");
    store_fault <= 1'b0;
    rtc_time <= 56'h19991301000000;
    exchange("T", "E07");
    init_scheduled <= 1'b1;
    sys_rst <= 1'b1;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    check_val(disp_text, 32'h494e4954);
    check_val(init_req, 1'b0);
    n = 0;
    while (init_clear !== 1'b1 && n < 900) begin
      @(posedge mclk);
      n++;
    end
    check_val(n < 900, 1'b1);
    check_val(rtc_load_value, 56'h19990101000000);
    init_scheduled <= 1'b0;
    rtc_time <= 56'h20240131235959;
    repeat (2) @(posedge mclk);
    check_val(disp_text, 32'h20202020);
    exchange("Y", "");
    exchange("D0000", "A0001");
    exchange("B05", "A00A1");
    finish_test();
  end
endmodule
